/* logic/pwr_seq_pkg.sv */
// Package for the power mode and wake sequencer: register map, fields, timing.
// Assumes a 125 MHz system clock and a 32-bit Avalon-MM register slave.
package pwr_seq_pkg;
  // Register byte addresses
  localparam logic [3:0] power_control_addr = 4'h0;
  localparam logic [3:0] auxiliary_control_addr = 4'h4;
  localparam logic [3:0] watchdog_ctrl_addr = 4'h8;
  localparam logic [3:0] status_addr = 4'hc;
  // Power control fields
  localparam int idle_bit = 0;
  localparam int pdown_bit = 1;
  // Auxiliary control fields
  localparam int brownout_detect_bit = 0;
  localparam int low_power_brownout_bit = 1;
  // Watchdog control fields
  localparam int wd_enable_bit = 0;
  localparam int wd_reset_en_bit = 1;
  localparam int wd_clear_bit = 2;
  localparam int wd_clock_select_bit = 3;
  localparam int wd_irq_flag_bit = 4;
  localparam int wd_reset_flag_bit = 5;
  // Reset values
  localparam logic [1:0] power_control_rst = 2'h0;
  localparam logic [1:0] auxiliary_control_rst = 2'h0;
  localparam logic [15:0] reset_vector = 16'h0000;
  // Timing
  localparam int states_per_cycle = 4;
  localparam int rst_hold_cycles = 2;
  localparam int wd_reset_delay_clk = 512;
  localparam logic [9:0] wd_reset_delay = 10'h200;
  localparam logic [15:0] wd_timeout_default = 16'hffff;
  // Machine cycle states, Gray coded
  typedef enum logic [1:0] {
    st_c1 = 2'b00,
    st_c2 = 2'b01,
    st_c3 = 2'b11,
    st_c4 = 2'b10
  } cycle_state_e;
  // Power modes, Gray coded
  typedef enum logic [1:0] {
    mode_run = 2'b00,
    mode_idle = 2'b01,
    mode_pdown = 2'b11,
    mode_reset = 2'b10
  } power_mode_e;
endpackage : pwr_seq_pkg

/* logic/power_mode_and_wake_sequencer.sv */
// Power mode and wake sequencer: machine-cycle pacing, idle and power-down,
// wake by interrupt or reset, external reset pin sampling, watchdog.
// Assumes the core fetches one opcode byte per fetch strobe and honours
// the clock enables; reset pin and interrupt pins are synchronous inputs.
`timescale 1ns/1ns
module power_mode_and_wake_sequencer (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic ext_reset_n_i,
  input wire logic por_i,
  input wire logic brownout_reset_i,
  input wire logic global_irq_enable_i,
  input wire logic ext_irq_i,
  input wire logic keypad_interrupt_i,
  input wire logic adc_irq_i,
  input wire logic periph_irq_i,
  input wire logic instr_end_i,
  input wire logic irq_return_i,
  input wire logic [7:0] port_latch_i,
  input wire logic [7:0] port_drive_i,
  output logic [1:0] cycle_state_o,
  output logic fetch_strobe_o,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic osc_en_o,
  output logic rc_clk_en_o,
  output logic core_reset_o,
  output logic [15:0] reset_vector_o,
  output logic irq_take_o,
  output logic skip_next_o,
  output logic [7:0] port_out_o,
  output logic [1:0] power_mode_o
);
  pwr_seq_pkg::cycle_state_e state;
  pwr_seq_pkg::cycle_state_e next_state;
  pwr_seq_pkg::power_mode_e mode;
  pwr_seq_pkg::power_mode_e next_mode;
  logic [1:0] power_control_reg;
  logic [1:0] auxiliary_control_reg;
  logic wd_enable, wd_reset_en, watchdog_clock_select, wd_irq_flag, watchdog_reset_flag;
  logic [15:0] wd_count;
  logic [9:0] wd_delay;
  logic wd_delay_run;
  logic [1:0] rst_low_cnt;
  logic [1:0] rst_hold_cnt;
  logic ext_reset_active;
  logic [1:0] wd_rst_cnt;
  logic pending_pd;
  logic pending_idle;
  logic woke_idle;
  logic [7:0] port_hold;
  logic [31:0] next_readdata;

  // Bus decode; the slave answers in the same cycle, so waitrequest stays low
  wire bus_wr = avs_write_i && avs_byteenable_i[0];
  wire wr_power_ctrl = bus_wr && avs_address_i == pwr_seq_pkg::power_control_addr;
  wire wr_aux = bus_wr && avs_address_i == pwr_seq_pkg::auxiliary_control_addr;
  wire wr_wd = bus_wr && avs_address_i == pwr_seq_pkg::watchdog_ctrl_addr;
  wire in_c4 = state == pwr_seq_pkg::st_c4;
  wire pd_req = wr_power_ctrl && avs_writedata_i[pwr_seq_pkg::pdown_bit];
  wire idle_req = wr_power_ctrl && avs_writedata_i[pwr_seq_pkg::idle_bit] && !pd_req;
  wire wd_clear = wr_wd && avs_writedata_i[pwr_seq_pkg::wd_clear_bit];
  wire wd_timeout = wd_enable && wd_count == 16'h0000;
  wire wd_fire = wd_delay_run && wd_delay == 10'h000 && wd_reset_en;
  // Oscillator-clocked watchdog cannot run in power-down
  wire wd_runs = mode != pwr_seq_pkg::mode_pdown || !watchdog_clock_select;
  wire idle_wake = periph_irq_i || wd_irq_flag || adc_irq_i || keypad_interrupt_i
                   || (global_irq_enable_i && ext_irq_i);
  wire pd_wake = (global_irq_enable_i && ext_irq_i) || keypad_interrupt_i || adc_irq_i
                 || (wd_irq_flag && !watchdog_clock_select);
  wire any_reset = ext_reset_active || brownout_reset_i || wd_rst_cnt != 2'h0;

  // Machine cycle sequencer; frozen only in power-down
  always_comb begin
    case (state)
      pwr_seq_pkg::st_c1: next_state = pwr_seq_pkg::st_c2;
      pwr_seq_pkg::st_c2: next_state = pwr_seq_pkg::st_c3;
      pwr_seq_pkg::st_c3: next_state = pwr_seq_pkg::st_c4;
      pwr_seq_pkg::st_c4: next_state = pwr_seq_pkg::st_c1;
      default: next_state = pwr_seq_pkg::st_c1;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state <= pwr_seq_pkg::st_c1;
    end else if (mode != pwr_seq_pkg::mode_pdown) begin
      state <= next_state;
    end
  end

  // Power mode transitions; reset outranks wake, which outranks entry
  always_comb begin
    next_mode = mode;
    case (mode)
      pwr_seq_pkg::mode_run: begin
        if (any_reset) begin
          next_mode = pwr_seq_pkg::mode_reset;
        end else if (instr_end_i && pending_pd) begin
          next_mode = pwr_seq_pkg::mode_pdown;
        end else if (instr_end_i && pending_idle) begin
          next_mode = pwr_seq_pkg::mode_idle;
        end
      end
      pwr_seq_pkg::mode_idle: begin
        if (any_reset) begin
          next_mode = pwr_seq_pkg::mode_reset;
        end else if (idle_wake) begin
          next_mode = pwr_seq_pkg::mode_run;
        end
      end
      pwr_seq_pkg::mode_pdown: begin
        if (!ext_reset_n_i || brownout_reset_i || wd_rst_cnt != 2'h0) begin
          next_mode = pwr_seq_pkg::mode_reset;
        end else if (pd_wake) begin
          next_mode = pwr_seq_pkg::mode_run;
        end
      end
      pwr_seq_pkg::mode_reset: begin
        if (!any_reset) begin
          next_mode = pwr_seq_pkg::mode_run;
        end
      end
      default: next_mode = pwr_seq_pkg::mode_reset;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mode <= pwr_seq_pkg::mode_reset;
    end else begin
      mode <= next_mode;
    end
  end

  // Pending entry requests wait for the writing instruction to finish
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pending_pd <= 1'b0;
      pending_idle <= 1'b0;
    end else if (mode == pwr_seq_pkg::mode_reset) begin
      pending_pd <= 1'b0;
      pending_idle <= 1'b0;
    end else begin
      pending_pd <= pd_req || (pending_pd && !(instr_end_i && mode == pwr_seq_pkg::mode_run));
      pending_idle <= idle_req
                      || (pending_idle && !(instr_end_i && mode == pwr_seq_pkg::mode_run));
    end
  end

  // Power control bits; hardware clears them on wake, which the set may override
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      power_control_reg <= pwr_seq_pkg::power_control_rst;
    end else if (pd_req) begin
      power_control_reg <= 2'h2;
    end else if (idle_req) begin
      power_control_reg <= 2'h1;
    end else if (mode == pwr_seq_pkg::mode_reset || next_mode == pwr_seq_pkg::mode_run) begin
      if (mode != pwr_seq_pkg::mode_run) begin
        power_control_reg <= pwr_seq_pkg::power_control_rst;
      end
    end
  end

  // Auxiliary and watchdog control bits
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      auxiliary_control_reg <= pwr_seq_pkg::auxiliary_control_rst;
      wd_enable <= 1'b0;
      wd_reset_en <= 1'b0;
      watchdog_clock_select <= 1'b0;
    end else if (mode == pwr_seq_pkg::mode_reset) begin
      auxiliary_control_reg <= pwr_seq_pkg::auxiliary_control_rst;
      wd_reset_en <= 1'b0;
    end else begin
      if (wr_aux) begin
        auxiliary_control_reg <= avs_writedata_i[1:0];
      end
      if (wr_wd) begin
        wd_enable <= avs_writedata_i[pwr_seq_pkg::wd_enable_bit];
        wd_reset_en <= avs_writedata_i[pwr_seq_pkg::wd_reset_en_bit];
        watchdog_clock_select <= avs_writedata_i[pwr_seq_pkg::wd_clock_select_bit];
      end
    end
  end

  // Watchdog counter keeps running in idle; time-out flag set wins over clear
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wd_count <= pwr_seq_pkg::wd_timeout_default;
      wd_irq_flag <= 1'b0;
      wd_delay <= pwr_seq_pkg::wd_reset_delay;
      wd_delay_run <= 1'b0;
    end else if (mode == pwr_seq_pkg::mode_reset || wd_clear) begin
      wd_count <= pwr_seq_pkg::wd_timeout_default;
      wd_irq_flag <= mode != pwr_seq_pkg::mode_reset && wd_runs && wd_timeout;
      wd_delay <= pwr_seq_pkg::wd_reset_delay;
      wd_delay_run <= 1'b0;
    end else if (wd_runs && wd_enable) begin
      wd_count <= wd_timeout ? pwr_seq_pkg::wd_timeout_default : wd_count - 16'h0001;
      if (wd_timeout) begin
        wd_irq_flag <= 1'b1;
        wd_delay_run <= 1'b1;
        wd_delay <= pwr_seq_pkg::wd_reset_delay - 10'h001;
      end else if (wd_delay_run && wd_delay != 10'h000) begin
        wd_delay <= wd_delay - 10'h001;
      end
    end
  end

  // Reset pin sampled in C4 (every clock in power-down), accepted after two low samples (one in power-down), held two cycles after
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rst_low_cnt <= 2'h0;
      rst_hold_cnt <= 2'h0;
      ext_reset_active <= 1'b0;
      wd_rst_cnt <= 2'h0;
    end else begin
      if (in_c4 || mode == pwr_seq_pkg::mode_pdown) begin
        if (!ext_reset_n_i) begin
          rst_low_cnt <= (rst_low_cnt == 2'h2) ? rst_low_cnt : rst_low_cnt + 2'h1;
          if (rst_low_cnt == 2'h1 || mode == pwr_seq_pkg::mode_pdown) begin
            ext_reset_active <= 1'b1;
            rst_hold_cnt <= 2'h2;
          end
        end else begin
          rst_low_cnt <= 2'h0;
          if (rst_hold_cnt != 2'h0) begin
            rst_hold_cnt <= rst_hold_cnt - 2'h1;
          end else begin
            ext_reset_active <= 1'b0;
          end
        end
      end
      if (wd_fire) begin
        wd_rst_cnt <= 2'h2;
      end else if (in_c4 && wd_rst_cnt != 2'h0) begin
        wd_rst_cnt <= wd_rst_cnt - 2'h1;
      end
    end
  end

  // Reset source flag: power-on clears, watchdog sets, external keeps
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      watchdog_reset_flag <= 1'b0;
    end else if (por_i) begin
      watchdog_reset_flag <= 1'b0;
    end else if (wd_fire) begin
      watchdog_reset_flag <= 1'b1;
    end
  end

  // Wake origin: an idle wake returns to the idling point, a power-down
  // wake to the next instruction; the core keeps its PC frozen either way
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      woke_idle <= 1'b0;
    end else if (mode == pwr_seq_pkg::mode_idle && next_mode == pwr_seq_pkg::mode_run) begin
      woke_idle <= 1'b1;
    end else if (mode == pwr_seq_pkg::mode_pdown && next_mode == pwr_seq_pkg::mode_run) begin
      woke_idle <= 1'b0;
    end else if (irq_return_i) begin
      woke_idle <= 1'b0;
    end
  end

  // Port levels captured on entry to idle; in power-down the outputs follow the port latch values
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      port_hold <= 8'hff;
    end else if (mode == pwr_seq_pkg::mode_run) begin
      port_hold <= port_drive_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      port_out_o <= 8'hff;
    end else if (next_mode == pwr_seq_pkg::mode_pdown) begin
      port_out_o <= port_latch_i;
    end else if (next_mode == pwr_seq_pkg::mode_idle) begin
      port_out_o <= port_hold;
    end else begin
      port_out_o <= port_drive_i;
    end
  end

  // Read data mux
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (avs_address_i)
      pwr_seq_pkg::power_control_addr: next_readdata[1:0] = power_control_reg;
      pwr_seq_pkg::auxiliary_control_addr: next_readdata[1:0] = auxiliary_control_reg;
      pwr_seq_pkg::watchdog_ctrl_addr: begin
        next_readdata[pwr_seq_pkg::wd_enable_bit] = wd_enable;
        next_readdata[pwr_seq_pkg::wd_reset_en_bit] = wd_reset_en;
        next_readdata[pwr_seq_pkg::wd_clock_select_bit] = watchdog_clock_select;
        next_readdata[pwr_seq_pkg::wd_irq_flag_bit] = wd_irq_flag;
        next_readdata[pwr_seq_pkg::wd_reset_flag_bit] = watchdog_reset_flag;
      end
      pwr_seq_pkg::status_addr: next_readdata[3:0] = {mode, state};
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  assign avs_readdata_o = avs_read_i ? next_readdata : 32'h0000_0000;
  assign avs_waitrequest_o = 1'b0;

  // Clock enables and core controls
  assign cycle_state_o = state;
  assign power_mode_o = mode;
  assign fetch_strobe_o = mode == pwr_seq_pkg::mode_run && state == pwr_seq_pkg::st_c1;
  assign cpu_clk_en_o = mode == pwr_seq_pkg::mode_run;
  assign periph_clk_en_o = mode != pwr_seq_pkg::mode_pdown;
  assign osc_en_o = mode != pwr_seq_pkg::mode_pdown;
  assign rc_clk_en_o = mode == pwr_seq_pkg::mode_pdown
                       && auxiliary_control_reg[pwr_seq_pkg::low_power_brownout_bit]
                       && !auxiliary_control_reg[pwr_seq_pkg::brownout_detect_bit];
  assign core_reset_o = mode == pwr_seq_pkg::mode_reset;
  assign reset_vector_o = pwr_seq_pkg::reset_vector;
  assign irq_take_o = mode != pwr_seq_pkg::mode_run && next_mode == pwr_seq_pkg::mode_run
                      && mode != pwr_seq_pkg::mode_reset;
  assign skip_next_o = mode == pwr_seq_pkg::mode_idle && any_reset;

  // Assertions
  sequence leaving_c4_s;
    state == pwr_seq_pkg::st_c4 && mode != pwr_seq_pkg::mode_pdown;
  endsequence
  cycle_order_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    leaving_c4_s |=> state == pwr_seq_pkg::st_c1) else $error("C4 not followed by C1");
  one_fetch_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    fetch_strobe_o |=> !fetch_strobe_o) else $error("Two fetches in one cycle");
  idle_entry_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    mode == pwr_seq_pkg::mode_run && instr_end_i && pending_idle && !pending_pd && !any_reset
    |=> mode == pwr_seq_pkg::mode_idle) else $error("Idle not entered");
  idle_clk_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    mode == pwr_seq_pkg::mode_idle |-> !cpu_clk_en_o && periph_clk_en_o)
    else $error("Idle clock gating wrong");
  idle_wake_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    mode == pwr_seq_pkg::mode_idle && idle_wake && !any_reset && !idle_req && !pd_req
    |=> mode == pwr_seq_pkg::mode_run && power_control_reg == 2'h0)
    else $error("Idle wake failed");
  pd_clocks_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    mode == pwr_seq_pkg::mode_pdown |-> !osc_en_o && !periph_clk_en_o ##1 $stable(state))
    else $error("Clock running in power-down");
  pd_ports_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    mode == pwr_seq_pkg::mode_pdown && $past(next_mode) == pwr_seq_pkg::mode_pdown
    |-> port_out_o == $past(port_latch_i)) else $error("Port not latch value");
  pd_reset_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    mode == pwr_seq_pkg::mode_pdown && !ext_reset_n_i |=> core_reset_o)
    else $error("Reset pin did not end power-down");
  rc_clock_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rc_clk_en_o |-> mode == pwr_seq_pkg::mode_pdown && auxiliary_control_reg == 2'h2)
    else $error("RC clock enable wrong");
  both_bits_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_power_ctrl && avs_writedata_i[1:0] == 2'h3 |=> power_control_reg == 2'h2 && pending_pd)
    else $error("Both bits not power-down");
  wd_flag_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wd_fire && !por_i |=> watchdog_reset_flag ##1 core_reset_o)
    else $error("Watchdog reset flag not set");
endmodule : power_mode_and_wake_sequencer

/* verification/far_side_model.sv */
// Far-side model: external reset pin, wake request lines, core strobes.
// Assumes one bench process calls its tasks; it drives on rising edges only.
`timescale 1ns/1ns
module far_side_model (
  input wire logic clk_sys_i,
  output logic ext_reset_n_o,
  output logic [3:0] wake_o,
  output logic instr_end_o,
  output logic irq_return_o
);
  // Pin is pulled up, so it idles high; wake lines idle inactive
  initial begin
    ext_reset_n_o = 1'b1;
    wake_o = 4'h0;
    instr_end_o = 1'b0;
    irq_return_o = 1'b0;
  end
  // Reset pin low for n clocks; short holds outside power-down show a refused reset
  task automatic hold_reset(input int n);
    @(posedge clk_sys_i);
    ext_reset_n_o <= 1'b0;
    repeat (n) @(posedge clk_sys_i);
    ext_reset_n_o <= 1'b1;
  endtask : hold_reset
  // Level requests stay up until the bench sees them served
  task automatic set_wake(input logic [3:0] v);
    @(posedge clk_sys_i);
    wake_o <= v;
  endtask : set_wake
  // One-cycle core strobe: instruction end, or return from service
  task automatic strobe(input logic ret);
    @(posedge clk_sys_i);
    instr_end_o <= !ret;
    irq_return_o <= ret;
    @(posedge clk_sys_i);
    instr_end_o <= 1'b0;
    irq_return_o <= 1'b0;
  endtask : strobe
endmodule : far_side_model

/* verification/tb_top.sv */
// Self-checking bench for the power mode and wake sequencer.
// Assumes the Avalon-MM register slave and far_side_model for pins and core.
`timescale 1ns/1ns
module tb_top;
  localparam logic [3:0] pc_a = pwr_seq_pkg::power_control_addr;
  localparam logic [3:0] aux_a = pwr_seq_pkg::auxiliary_control_addr;
  localparam logic [3:0] wd_a = pwr_seq_pkg::watchdog_ctrl_addr;
  localparam logic [1:0] m_run = pwr_seq_pkg::mode_run;
  localparam logic [1:0] m_idle = pwr_seq_pkg::mode_idle;
  localparam logic [1:0] m_pd = pwr_seq_pkg::mode_pdown;
  localparam logic [1:0] m_rst = pwr_seq_pkg::mode_reset;
  logic clk_sys_i;
  logic rst_i;
  logic [3:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0] avs_byteenable_i;
  logic por_i;
  logic brownout_reset_i;
  logic global_irq_enable_i;
  logic [7:0] port_latch_i;
  logic [7:0] port_drive_i;
  logic [31:0] avs_readdata_o, rd;
  logic avs_waitrequest_o, ext_reset_n, instr_end, irq_return, seen;
  logic [3:0] wake;
  logic [1:0] cycle_state_o, power_mode_o;
  logic fetch_strobe_o, cpu_clk_en_o, periph_clk_en_o, osc_en_o, rc_clk_en_o;
  logic core_reset_o, irq_take_o, skip_next_o;
  logic [15:0] reset_vector_o;
  logic [7:0] port_out_o;
  logic [1:0] seq [4];
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int i, k;

  // 125 MHz system clock
  always #4 clk_sys_i = ~clk_sys_i;

  power_mode_and_wake_sequencer uut (
    .clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .ext_reset_n_i(ext_reset_n), .por_i, .brownout_reset_i, .global_irq_enable_i,
    .ext_irq_i(wake[0]), .keypad_interrupt_i(wake[1]), .adc_irq_i(wake[2]),
    .periph_irq_i(wake[3]), .instr_end_i(instr_end), .irq_return_i(irq_return),
    .port_latch_i, .port_drive_i, .cycle_state_o, .fetch_strobe_o, .cpu_clk_en_o,
    .periph_clk_en_o, .osc_en_o, .rc_clk_en_o, .core_reset_o, .reset_vector_o,
    .irq_take_o, .skip_next_o, .port_out_o, .power_mode_o
  );
  far_side_model fs (
    .clk_sys_i, .ext_reset_n_o(ext_reset_n), .wake_o(wake), .instr_end_o(instr_end),
    .irq_return_o(irq_return)
  );

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // Hang guard: watchdog run needs about 66k cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  // Bus cycles hold the request until waitrequest is seen low
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= 1'b1;
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_sys_i);
    avs_write_i <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_sys_i);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    check(rd, exp, "read");
  endtask : bus_rd
  // Bounded waits, sampled on the falling edge where outputs have settled
  task automatic wait_mode(input logic [1:0] m, input int lim);
    @(negedge clk_sys_i);
    for (int j = 0; j < lim && power_mode_o !== m; j++) @(negedge clk_sys_i);
    check(32'(power_mode_o), 32'(m), "mode");
  endtask : wait_mode
  task automatic wait_take(input int lim);
    for (int j = 0; j < lim && irq_take_o !== 1'b1; j++) @(negedge clk_sys_i);
    check(32'(irq_take_o), 32'h1, "wake pulse");
    // The mode register follows the wake pulse one edge later
    @(negedge clk_sys_i);
  endtask : wait_take
  // Mode entry: register write, then the last instruction ends
  task automatic enter(input logic [31:0] bits, input logic [1:0] m);
    bus_wr(pc_a, bits);
    fs.strobe(1'b0);
    wait_mode(m, 4);
  endtask : enter

  initial begin
    seq = '{pwr_seq_pkg::st_c1, pwr_seq_pkg::st_c2, pwr_seq_pkg::st_c3, pwr_seq_pkg::st_c4};
    // Start values, set before the first clock edge
    clk_sys_i = 1'b0;
    rst_i = 1'b1;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    por_i = 1'b0;
    brownout_reset_i = 1'b0;
    global_irq_enable_i = 1'b1;
    port_latch_i = 8'h3c;
    port_drive_i = 8'h5a;
    repeat (10) @(posedge clk_sys_i);
    check(32'({power_mode_o, core_reset_o, port_out_o}), 32'({m_rst, 1'b1, 8'hff}),
          "in reset");
    rst_i <= 1'b0;
    wait_mode(m_run, 4);
    bus_rd(pc_a, 32'h0);
    bus_rd(aux_a, 32'h0);
    bus_wr(4'h2, 32'hff);
    bus_rd(4'h2, 32'h0);
    // A write without lane 0 enabled is ignored
    @(posedge clk_sys_i);
    avs_byteenable_i <= 4'he;
    bus_wr(aux_a, 32'h3);
    bus_rd(aux_a, 32'h0);
    avs_byteenable_i <= 4'hf;
    // Machine-cycle pacing, one fetch per cycle
    @(negedge clk_sys_i);
    for (k = 0; k < 4 && cycle_state_o !== seq[0]; k++) @(negedge clk_sys_i);
    for (k = 0; k < 8; k++) begin
      check(32'(cycle_state_o), 32'(seq[k % 4]), "state");
      check(32'(fetch_strobe_o), 32'(k % 4 == 0), "fetch");
      @(negedge clk_sys_i);
    end
    // Idle: CPU clock stops, ports frozen, peripheral wake
    enter(32'h1, m_idle);
    check(32'({cpu_clk_en_o, periph_clk_en_o, osc_en_o}), 32'h3, "idle clocks");
    @(posedge clk_sys_i);
    port_drive_i <= 8'ha5;
    repeat (4) @(negedge clk_sys_i);
    check(32'(port_out_o), 32'h5a, "idle port");
    fs.set_wake(4'h8);
    wait_take(16);
    check(32'(power_mode_o), 32'(m_run), "idle wake");
    fs.set_wake(4'h0);
    fs.strobe(1'b1);
    bus_rd(pc_a, 32'h0);
    // Power-down; external interrupt needs the global enable
    bus_wr(pc_a, 32'h3);
    bus_rd(pc_a, 32'h2);
    fs.strobe(1'b0);
    wait_mode(m_pd, 4);
    check(32'({cpu_clk_en_o, periph_clk_en_o, osc_en_o, rc_clk_en_o}), 32'h0, "pd clk");
    check(32'(port_out_o), 32'h3c, "pd port");
    @(posedge clk_sys_i);
    global_irq_enable_i <= 1'b0;
    port_latch_i <= 8'hc3;
    fs.set_wake(4'h1);
    repeat (16) @(negedge clk_sys_i);
    check(32'(power_mode_o), 32'(m_pd), "masked wake");
    check(32'(port_out_o), 32'hc3, "pd latch follow");
    @(posedge clk_sys_i);
    global_irq_enable_i <= 1'b1;
    wait_take(16);
    check(32'({osc_en_o, power_mode_o}), 32'({1'b1, m_run}), "osc restart");
    fs.set_wake(4'h0);
    fs.strobe(1'b1);
    // Other wake sources with the RC clock kept on in power-down
    bus_wr(aux_a, 32'h2);
    for (i = 0; i < 3; i++) begin
      enter(32'h2, m_pd);
      check(32'(rc_clk_en_o), 32'h1, "rc clock");
      @(posedge clk_sys_i);
      brownout_reset_i <= (i == 2);
      fs.set_wake(i == 0 ? 4'h2 : (i == 1 ? 4'h4 : 4'h0));
      for (k = 0; k < 16 && power_mode_o === m_pd; k++) @(negedge clk_sys_i);
      check(32'(power_mode_o === m_pd), 32'h0, "pd wake");
      @(posedge clk_sys_i);
      brownout_reset_i <= 1'b0;
      fs.set_wake(4'h0);
      wait_mode(m_run, 64);
    end
    bus_wr(aux_a, 32'h0);
    // Reset pin in idle: one low sample refused, a long hold accepted
    enter(32'h1, m_idle);
    fs.hold_reset(4);
    repeat (12) @(negedge clk_sys_i);
    check(32'(power_mode_o), 32'(m_idle), "short pin");
    seen = 1'b0;
    fork
      fs.hold_reset(12);
      repeat (12) begin
        @(negedge clk_sys_i);
        seen = seen | (skip_next_o === 1'b1);
      end
    join
    check(32'(seen), 32'h1, "skip next");
    check(32'({power_mode_o, core_reset_o, reset_vector_o}), 32'({m_rst, 1'b1, 16'h0000}),
          "rst");
    repeat (3) @(negedge clk_sys_i);
    check(32'(power_mode_o), 32'(m_rst), "reset hold");
    wait_mode(m_run, 16);
    // Reset pin ends power-down
    enter(32'h2, m_pd);
    fs.hold_reset(2);
    wait_mode(m_rst, 8);
    check(32'(osc_en_o), 32'h1, "pd reset osc");
    wait_mode(m_run, 16);
    // Watchdog wakes idle, then resets 512 clocks after time-out
    bus_wr(wd_a, 32'h3);
    enter(32'h1, m_idle);
    wait_take(70000);
    for (k = 0; k < 600 && core_reset_o !== 1'b1; k++) @(negedge clk_sys_i);
    check(32'(k >= 504 && k <= 516), 32'h1, "wd delay");
    wait_mode(m_run, 32);
    bus_rd(wd_a, 32'h21);
    fs.hold_reset(12);
    wait_mode(m_run, 32);
    bus_rd(wd_a, 32'h21);
    @(posedge clk_sys_i);
    por_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    por_i <= 1'b0;
    wait_mode(m_run, 32);
    bus_rd(wd_a, 32'h1);
    wrap_up();
  end
endmodule : tb_top
